// >>> hdl/mal_alu_top.sv
// The address map and register access over AXI4-Lite are this design's own decisions.
`include "mal_map.svh"
module mal_alu_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);
  import mal_pkg::*;
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic [31:0]       wmask;
  logic [7:0]        wr_addr;
  logic [7:0]        rd_addr;
  logic              wr_fire;
  logic              wr_err;
  logic              wr_ok;
  logic              go;
  logic [31:0]       rd_data;
  logic              rd_err;
  mal_state_type     state_reg;
  logic [1:0]        count_reg;
  logic [1:0]        cyc_reg;
  logic [1:0]        cyc_next;
  mal_op_type        op_reg;
  mal_op_type        op_next;
  logic [15:0]       dest_reg;
  logic [7:0]        src_reg;
  logic [5:0]        sreg_reg;
  logic [15:0]       prod_reg;
  logic              busy;
  logic              commit;
  logic              is_word;
  logic              is_mult;
  logic              is_frac;
  logic              a_sgn;
  logic              b_sgn;
  logic [7:0]        byte_res;
  logic [5:0]        byte_flg;
  logic [5:0]        byte_upd;
  logic [15:0]       mult_prod;
  logic              mult_c;
  logic              mult_z;
  logic [15:0]       k_word;
  logic [15:0]       word_res;
  logic              word_v;
  logic              word_c;
  logic [5:0]        new_flg;
  logic [5:0]        new_upd;

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ----------------------------------------------------------------------
  // bus write side
  // ----------------------------------------------------------------------
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_lane
    assign wmask[gi*8 +: 8] = {8{wstrb_reg[gi]}};
  end

  assign wr_addr = {awaddr_reg[7:2], 2'b00};
  assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign op_next = mal_op_type'(wdata_reg[4:0]);
  assign busy    = (state_reg != mal_st_idle);

  // writes during an operation are refused so operands stay still
  always_comb begin
    wr_err = busy;
    case (wr_addr)
      `MAL_REG_CTRL: begin
        if (wdata_reg[4:0] > op_frac_mult_mixed) begin
          wr_err = 1'b1;
        end
      end
      `MAL_REG_DEST, `MAL_REG_SRC, `MAL_REG_SREG: wr_err = busy;
      default: wr_err = 1'b1;
    endcase
  end

  assign wr_ok = wr_fire & ~wr_err;
  assign go = wr_ok & (wr_addr == `MAL_REG_CTRL) & wstrb_reg[0];

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      awready_reg <= 1'b1;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid && awready_reg) begin
      aw_held_reg <= 1'b1;
      awready_reg <= 1'b0;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end else if (bvalid_reg && s_axi_bready) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      w_held_reg <= 1'b0;
      wready_reg <= 1'b1;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && wready_reg) begin
      w_held_reg <= 1'b1;
      wready_reg <= 1'b0;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end else if (bvalid_reg && s_axi_bready) begin
      wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `MAL_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_err ? `MAL_RESP_SLVERR : `MAL_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // bus read side
  // ----------------------------------------------------------------------
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};

  always_comb begin
    rd_err = 1'b0;
    case (rd_addr)
      `MAL_REG_CTRL: rd_data = {27'h000_0000, op_reg};
      `MAL_REG_DEST: rd_data = {16'h0000, dest_reg};
      `MAL_REG_SRC:  rd_data = {24'h00_0000, src_reg};
      `MAL_REG_SREG: rd_data = {26'h000_0000, sreg_reg};
      `MAL_REG_PROD: rd_data = {16'h0000, prod_reg};
      `MAL_REG_STAT: rd_data = {28'h000_0000, cyc_reg, 1'b0, busy};
      default: begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `MAL_RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_data;
      rresp_reg <= rd_err ? `MAL_RESP_SLVERR : `MAL_RESP_OKAY;
    end else if (rvalid_reg && s_axi_rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // operation sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    case (op_next)
      op_word_add_imm, op_word_subtract_imm: cyc_next = `MAL_CYC_WORD;
      op_mult_unsigned, op_mult_signed, op_mult_signed_unsigned,
      op_frac_mult_unsigned, op_frac_mult_signed, op_frac_mult_mixed:
        cyc_next = `MAL_CYC_MULT;
      default: cyc_next = `MAL_CYC_BYTE;
    endcase
  end

  assign commit = (state_reg == mal_st_run) && (count_reg == 2'h1);

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= mal_st_idle;
      count_reg <= 2'h0;
      cyc_reg <= 2'h0;
      op_reg <= op_add;
    end else if (go) begin
      state_reg <= mal_st_run;
      count_reg <= cyc_next;
      cyc_reg <= cyc_next;
      op_reg <= op_next;
    end else if (commit) begin
      state_reg <= mal_st_idle;
      count_reg <= 2'h0;
    end else if (busy) begin
      count_reg <= count_reg - 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------------
  always_comb begin
    is_word = 1'b0;
    is_mult = 1'b1;
    is_frac = 1'b0;
    a_sgn = 1'b0;
    b_sgn = 1'b0;
    case (op_reg)
      op_word_add_imm, op_word_subtract_imm: begin
        is_word = 1'b1;
        is_mult = 1'b0;
      end
      op_mult_unsigned: a_sgn = 1'b0;
      op_mult_signed: begin
        a_sgn = 1'b1;
        b_sgn = 1'b1;
      end
      op_mult_signed_unsigned: a_sgn = 1'b1;
      op_frac_mult_unsigned: is_frac = 1'b1;
      op_frac_mult_signed: begin
        is_frac = 1'b1;
        a_sgn = 1'b1;
        b_sgn = 1'b1;
      end
      op_frac_mult_mixed: begin
        is_frac = 1'b1;
        a_sgn = 1'b1;
      end
      default: is_mult = 1'b0;
    endcase
  end

  mal_byte_unit u_byte (
    .op  (op_reg),
    .a   (dest_reg[7:0]),
    .b   (src_reg),
    .cin (sreg_reg[`MAL_FC]),
    .res (byte_res),
    .flg (byte_flg),
    .upd (byte_upd)
  );

  mal_mult_unit u_mult (
    .a        (dest_reg[7:0]),
    .b        (src_reg),
    .a_signed (a_sgn),
    .b_signed (b_sgn),
    .frac     (is_frac),
    .prod     (mult_prod),
    .carry    (mult_c),
    .zero     (mult_z)
  );

  // word constant is six bits wide, pair is dest high:low
  assign k_word = {10'h000, src_reg[`MAL_WORD_K_W-1:0]};

  always_comb begin
    if (op_reg == op_word_subtract_imm) begin
      word_res = dest_reg - k_word;
      word_v = dest_reg[15] & ~word_res[15];
      word_c = word_res[15] & ~dest_reg[15];
    end else begin
      word_res = dest_reg + k_word;
      word_v = ~dest_reg[15] & word_res[15];
      word_c = ~word_res[15] & dest_reg[15];
    end
  end

  always_comb begin
    new_flg = byte_flg;
    new_upd = byte_upd;
    if (is_word) begin
      new_upd = `MAL_UPD_ZCNVS;
      new_flg[`MAL_FC] = word_c;
      new_flg[`MAL_FZ] = (word_res == 16'h0000);
      new_flg[`MAL_FN] = word_res[15];
      new_flg[`MAL_FV] = word_v;
      new_flg[`MAL_FS] = word_res[15] ^ word_v;
    end else if (is_mult) begin
      new_upd = `MAL_UPD_ZC;
      new_flg[`MAL_FC] = mult_c;
      new_flg[`MAL_FZ] = mult_z;
    end
  end

  // ----------------------------------------------------------------------
  // architectural state
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      dest_reg <= 16'h0000;
    end else if (wr_ok && wr_addr == `MAL_REG_DEST) begin
      dest_reg <= (dest_reg & ~wmask[15:0]) | (wdata_reg[15:0] & wmask[15:0]);
    end else if (commit && is_word) begin
      dest_reg <= word_res;
    end else if (commit && !is_mult) begin
      dest_reg[7:0] <= byte_res;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      src_reg <= `MAL_ZERO;
    end else if (wr_ok && wr_addr == `MAL_REG_SRC && wstrb_reg[0]) begin
      src_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sreg_reg <= `MAL_SREG_RST;
    end else if (wr_ok && wr_addr == `MAL_REG_SREG && wstrb_reg[0]) begin
      sreg_reg <= wdata_reg[5:0];
    end else if (commit) begin
      sreg_reg <= (sreg_reg & ~new_upd) | (new_flg & new_upd);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prod_reg <= 16'h0000;
    end else if (commit && is_mult) begin
      prod_reg <= mult_prod;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic [7:0] sub_ref;
  logic       dest_sw;
  assign sub_ref = dest_reg[7:0] - src_reg[7:0];
  assign dest_sw = wr_ok && wr_addr == `MAL_REG_DEST;

  a_byte_one_cycle: assert property (
    go && cyc_next == `MAL_CYC_BYTE |=> commit)
    else $error("byte op did not complete in one cycle");

  a_word_two_cycle: assert property (
    go && (op_next == op_word_add_imm) |=> !commit ##1 commit)
    else $error("word op did not take two cycles");

  a_mult_two_cycle: assert property (
    go && (op_next == op_mult_signed) |=> !commit ##1 commit)
    else $error("multiply did not take two cycles");

  a_sub_result: assert property (
    commit && op_reg == op_subtract |=> dest_reg[7:0] == $past(sub_ref))
    else $error("subtract result wrong");

  a_logic_v_clear: assert property (
    commit && (op_reg == op_and || op_reg == op_or_imm) |=>
      !sreg_reg[`MAL_FV])
    else $error("logical op left overflow set");

  a_com_carry_set: assert property (
    commit && op_reg == op_ones_complement |=> sreg_reg[`MAL_FC])
    else $error("complement did not set carry");

  a_set_reg_flags: assert property (
    commit && op_reg == op_set_reg |=>
      dest_reg[7:0] == `MAL_ONES && $stable(sreg_reg))
    else $error("set register wrong or touched flags");

  a_frac_shift: assert property (
    commit && is_frac |=> !prod_reg[0])
    else $error("fractional product not shifted");

  a_word_sign: assert property (
    commit && is_word |=>
      sreg_reg[`MAL_FS] == (sreg_reg[`MAL_FN] ^ sreg_reg[`MAL_FV]))
    else $error("word sign flag not n xor v");

  a_dest_hold: assert property (
    !commit && !dest_sw |=> $stable(dest_reg))
    else $error("destination changed outside completion");

  c_word_sub: cover property (go && op_next == op_word_subtract_imm);
  c_frac_mult: cover property (commit && is_frac);
  c_refused: cover property (wr_fire && wr_err);
  c_back_to_back: cover property (commit ##1 go);
endmodule // mal_alu_top

// >>> hdl/mal_map.svh
`ifndef MAL_MAP_SVH
`define MAL_MAP_SVH
// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define MAL_REG_CTRL    8'h00
`define MAL_REG_DEST    8'h04
`define MAL_REG_SRC     8'h08
`define MAL_REG_SREG    8'h0c
`define MAL_REG_PROD    8'h10
`define MAL_REG_STAT    8'h14
// ----------------------------------------------------------------------
// status flag positions
// ----------------------------------------------------------------------
`define MAL_FC          0
`define MAL_FZ          1
`define MAL_FN          2
`define MAL_FV          3
`define MAL_FS          4
`define MAL_FH          5
// ----------------------------------------------------------------------
// flag update masks
// ----------------------------------------------------------------------
`define MAL_UPD_ZCNVH   6'h2f
`define MAL_UPD_ZCNVS   6'h1f
`define MAL_UPD_ZCNV    6'h0f
`define MAL_UPD_ZNV     6'h0e
`define MAL_UPD_ZC      6'h03
`define MAL_UPD_NONE    6'h00
// ----------------------------------------------------------------------
// cycle counts, constants, reset values
// ----------------------------------------------------------------------
`define MAL_CYC_BYTE    2'h1
`define MAL_CYC_WORD    2'h2
`define MAL_CYC_MULT    2'h2
`define MAL_ONES        8'hff
`define MAL_ZERO        8'h00
`define MAL_ONE         8'h01
`define MAL_WORD_K_W    6
`define MAL_SREG_RST    6'h00
`define MAL_RESP_OKAY   2'h0
`define MAL_RESP_SLVERR 2'h2
`endif

// >>> hdl/mal_pkg.sv
package mal_pkg;
  typedef enum logic [4:0] {
    op_add, op_add_carry, op_word_add_imm, op_subtract, op_subtract_imm,
    op_subtract_borrow, op_subtract_borrow_imm, op_word_subtract_imm,
    op_and, op_and_imm, op_or, op_or_imm, op_xor, op_ones_complement,
    op_twos_complement, op_set_bits, op_clear_bits, op_increment,
    op_decrement, op_test, op_clear_reg, op_set_reg, op_mult_unsigned,
    op_mult_signed, op_mult_signed_unsigned, op_frac_mult_unsigned,
    op_frac_mult_signed, op_frac_mult_mixed
  } mal_op_type;
  typedef enum logic [1:0] {
    mal_st_idle = 2'b00,
    mal_st_run  = 2'b01
  } mal_state_type;
endpackage

// >>> hdl/mal_byte_unit.sv
`include "mal_map.svh"
module mal_byte_unit (
  input  wire mal_pkg::mal_op_type op,
  input  wire logic [7:0]          a,
  input  wire logic [7:0]          b,
  input  wire logic                cin,
  output logic [7:0]               res,
  output logic [5:0]               flg,
  output logic [5:0]               upd
);
  import mal_pkg::*;
  logic [7:0] m;
  logic [7:0] x;
  logic [7:0] lres;
  logic       cy;
  logic       sub;
  logic       arith;
  logic [8:0] full;
  logic [4:0] half;
  // ----------------------------------------------------------------------
  // operand steering
  // ----------------------------------------------------------------------
  always_comb begin
    m = a;
    x = b;
    cy = 1'b0;
    sub = 1'b0;
    arith = 1'b1;
    lres = a & b;
    upd = `MAL_UPD_ZCNVH;
    case (op)
      op_add_carry: cy = cin;
      op_subtract, op_subtract_imm: sub = 1'b1;
      op_subtract_borrow, op_subtract_borrow_imm: begin
        sub = 1'b1;
        cy = cin;
      end
      op_twos_complement: begin
        m = `MAL_ZERO;
        x = a;
        sub = 1'b1;
      end
      op_ones_complement: begin
        arith = 1'b0;
        lres = `MAL_ONES - a;
        upd = `MAL_UPD_ZCNV;
      end
      op_increment, op_decrement: begin
        x = `MAL_ONE;
        sub = (op == op_decrement);
        upd = `MAL_UPD_ZNV;
      end
      op_and, op_and_imm, op_test: begin
        arith = 1'b0;
        lres = (op == op_test) ? a : (a & b);
        upd = `MAL_UPD_ZNV;
      end
      op_or, op_or_imm, op_set_bits: begin
        arith = 1'b0;
        lres = a | b;
        upd = `MAL_UPD_ZNV;
      end
      op_xor, op_clear_reg: begin
        arith = 1'b0;
        lres = (op == op_clear_reg) ? `MAL_ZERO : (a ^ b);
        upd = `MAL_UPD_ZNV;
      end
      op_clear_bits: begin
        arith = 1'b0;
        lres = a & (`MAL_ONES - b);
        upd = `MAL_UPD_ZNV;
      end
      op_set_reg: begin
        arith = 1'b0;
        lres = `MAL_ONES;
        upd = `MAL_UPD_NONE;
      end
      default: cy = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------------
  // adder and flags
  // ----------------------------------------------------------------------
  always_comb begin
    if (sub) begin
      full = {1'b0, m} - {1'b0, x} - {8'h00, cy};
      half = {1'b0, m[3:0]} - {1'b0, x[3:0]} - {4'h0, cy};
    end else begin
      full = {1'b0, m} + {1'b0, x} + {8'h00, cy};
      half = {1'b0, m[3:0]} + {1'b0, x[3:0]} + {4'h0, cy};
    end
    res = arith ? full[7:0] : lres;
    flg[`MAL_FC] = arith ? full[8] : 1'b1;
    flg[`MAL_FZ] = (res == `MAL_ZERO);
    flg[`MAL_FN] = res[7];
    // signed overflow of bit 7, carry or borrow out of bit 3
    flg[`MAL_FV] = arith & ((m[7] ^ x[7]) == sub) & (res[7] != m[7]);
    flg[`MAL_FS] = flg[`MAL_FN] ^ flg[`MAL_FV];
    flg[`MAL_FH] = half[4];
  end
endmodule // mal_byte_unit

// >>> hdl/mal_mult_unit.sv
module mal_mult_unit (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       a_signed,
  input  wire logic       b_signed,
  input  wire logic       frac,
  output logic [15:0]     prod,
  output logic            carry,
  output logic            zero
);
  logic signed [8:0]  sa;
  logic signed [8:0]  sb;
  logic signed [17:0] p;
  logic [15:0]        raw;
  // nine bits so unsigned and signed operands share one multiplier
  assign sa = {a_signed & a[7], a};
  assign sb = {b_signed & b[7], b};
  assign p = sa * sb;
  assign raw = p[15:0];
  assign carry = raw[15];
  assign prod = frac ? {raw[14:0], 1'b0} : raw;
  assign zero = (prod == 16'h0000);
endmodule // mal_mult_unit

// >>> verification/mal_host.sv
// ----------------------------------------------------------------
// decoder side: issues register bus transfers into the datapath
// ----------------------------------------------------------------
module mal_host (
  input  wire logic  mclk,
  output logic       s_axi_awvalid,
  input  wire logic  s_axi_awready,
  output logic [7:0] s_axi_awaddr,
  output logic       s_axi_wvalid,
  input  wire logic  s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  input  wire logic  s_axi_bvalid,
  output logic       s_axi_bready,
  input  wire logic [1:0] s_axi_bresp,
  output logic       s_axi_arvalid,
  input  wire logic  s_axi_arready,
  output logic [7:0] s_axi_araddr,
  input  wire logic  s_axi_rvalid,
  output logic       s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0] s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    s_axi_awvalid <= 1'b0;
    s_axi_awaddr <= 8'h00;
    s_axi_wvalid <= 1'b0;
    s_axi_wdata <= 32'h0000_0000;
    s_axi_wstrb <= 4'hf;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= 8'h00;
    s_axi_rready <= 1'b0;
  end
  // iff sees pre-edge values, so a handshake is judged as the slave saw it
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge mclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    fork
      begin
        @(posedge mclk iff s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        @(posedge mclk iff s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    @(posedge mclk iff s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge mclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    @(posedge mclk iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge mclk iff s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // mal_host

// >>> verification/mal_alu_top_tb.sv
module mal_alu_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          bad_count, comparisons;
  typedef struct packed {
    logic [15:0] d;
    logic [7:0]  s;
    logic [5:0]  f;
    logic [15:0] e;
    logic [5:0]  ef;
  } mal_vec_type;
  // ----------------------------------------------------------------
  // one row per opcode: dest, src, flags in, result, flags out
  // ----------------------------------------------------------------
  mal_vec_type vt [28] = '{
    '{16'h1278, 8'h08, 6'h11, 16'h1280, 6'h3c},
    '{16'h00ff, 8'h00, 6'h01, 16'h0000, 6'h23},
    '{16'h7fff, 8'hc1, 6'h20, 16'h8000, 6'h2c},
    '{16'h0010, 8'h01, 6'h00, 16'h000f, 6'h20},
    '{16'h0080, 8'h01, 6'h10, 16'h007f, 6'h38},
    '{16'h0000, 8'h00, 6'h01, 16'h00ff, 6'h25},
    '{16'h0005, 8'h04, 6'h01, 16'h0000, 6'h02},
    '{16'h0000, 8'h01, 6'h20, 16'hffff, 6'h35},
    '{16'h00f0, 8'h3c, 6'h3f, 16'h0030, 6'h31},
    '{16'h000f, 8'hf0, 6'h00, 16'h0000, 6'h02},
    '{16'h0080, 8'h01, 6'h00, 16'h0081, 6'h04},
    '{16'h0000, 8'h00, 6'h08, 16'h0000, 6'h02},
    '{16'h00aa, 8'hff, 6'h06, 16'h0055, 6'h00},
    '{16'h00ff, 8'h00, 6'h20, 16'h0000, 6'h23},
    '{16'h0001, 8'h00, 6'h00, 16'h00ff, 6'h25},
    '{16'h0001, 8'h80, 6'h01, 16'h0081, 6'h05},
    '{16'h00ff, 8'h0f, 6'h00, 16'h00f0, 6'h04},
    '{16'h007f, 8'h00, 6'h01, 16'h0080, 6'h0d},
    '{16'h0080, 8'h00, 6'h00, 16'h007f, 6'h08},
    '{16'h0000, 8'h00, 6'h0c, 16'h0000, 6'h02},
    '{16'h345a, 8'h00, 6'h00, 16'h3400, 6'h02},
    '{16'h0012, 8'h00, 6'h2a, 16'h00ff, 6'h2a},
    '{16'h00ff, 8'hff, 6'h3c, 16'hfe01, 6'h3d},
    '{16'h00ff, 8'hff, 6'h03, 16'h0001, 6'h00},
    '{16'h00ff, 8'h02, 6'h00, 16'hfffe, 6'h01},
    '{16'h0080, 8'h80, 6'h00, 16'h8000, 6'h00},
    '{16'h00c0, 8'h40, 6'h00, 16'he000, 6'h01},
    '{16'h0000, 8'h55, 6'h01, 16'h0000, 6'h02}
  };
  mal_alu_top u_dut (.*);
  mal_host h (.*);
  task automatic chk(input string n, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // generous: the whole sequence needs well under two thousand cycles
  initial begin
    #1_000_000;
    bad_count++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    logic [1:0]  cyc;
    rst = 1'b1;
    bad_count = 0;
    comparisons = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    h.rd(8'h0c, v, r);
    chk("flags after reset", v, 32'h0000_0000);
    // reads issued after the response already see a finished op
    foreach (vt[i]) begin
      cyc = (i == 2 || i == 7 || i >= 22) ? 2'h2 : 2'h1;
      h.wr(8'h04, 32'(vt[i].d), r);
      h.wr(8'h08, 32'(vt[i].s), r);
      h.wr(8'h0c, 32'(vt[i].f), r);
      h.wr(8'h00, 32'(i), r);
      chk("start resp", 32'(r), 32'h0000_0000);
      h.rd(i >= 22 ? 8'h10 : 8'h04, v, r);
      chk("result", v, 32'(vt[i].e));
      h.rd(8'h0c, v, r);
      chk("flags", v, 32'(vt[i].ef));
      h.rd(8'h14, v, r);
      chk("cycles", v, 32'({cyc, 2'b00}));
      if (i >= 22) begin
        h.rd(8'h04, v, r);
        chk("dest kept", v, 32'(vt[i].d));
      end
    end
    h.wr(8'h10, 32'h0000_1234, r);
    chk("product write resp", 32'(r), 32'h0000_0002);
    h.rd(8'h10, v, r);
    chk("product kept", v, 32'h0000_0000);
    h.wr(8'h00, 32'h0000_001c, r);
    chk("bad opcode resp", 32'(r), 32'h0000_0002);
    h.rd(8'h18, v, r);
    chk("unmapped resp", 32'(r), 32'h0000_0002);
    chk("unmapped data", v, 32'h0000_0000);
    stop_test();
  end
endmodule // mal_alu_top_tb
